// >>> logic/ddr_map.svh
// constants of the registered ddr module: command codes, config encodings,
// widths and presence-detect addressing; included by the package only
`ifndef DDR_MAP_SVH
`define DDR_MAP_SVH
// -----------------------------------------------------------------------------
// widths
// -----------------------------------------------------------------------------
`define DQ_W          8
`define COL_W         13
`define MEM_AW        7
`define PD_BYTES      256
`define PD_MAKER      128
// -----------------------------------------------------------------------------
// command codes {ras_n, cas_n, we_n}
// -----------------------------------------------------------------------------
`define CMD_CFG_SET   3'h0
`define CMD_PRECHARGE 3'h2
`define CMD_ACTIVATE  3'h3
`define CMD_WRITE     3'h4
`define CMD_READ      3'h5
// -----------------------------------------------------------------------------
// config register encodings
// -----------------------------------------------------------------------------
`define BL_2          3'h1
`define BL_4          3'h2
`define BL_8          3'h3
`define CL_2          3'h2
`define CL_25         3'h6
`define CL_2_CYC      2'h2
`define CL_25_CYC     2'h3
`define MODE_DLL_BIT  1
`define AP_BIT        10
// -----------------------------------------------------------------------------
// presence detect
// -----------------------------------------------------------------------------
`define PD_DEV_TYPE   4'hA
`endif

// >>> logic/ddr_pkg.sv
// types of the registered ddr module
// assumes ddr_map.svh sits beside it on the include path
`default_nettype none
package ddr_pkg;
`include "ddr_map.svh"
	typedef struct packed {
		logic        cs_n;
		logic        ras_n;
		logic        cas_n;
		logic        we_n;
		logic [1:0]  ba;
		logic [13:0] addr;
	} cmd_t;
	typedef struct packed {
		logic [6:0] mode;
		logic [2:0] cl;
		logic       bt;
		logic [2:0] bl;
	} cfg_t;
	typedef enum logic [3:0] {
		PD_IDLE, PD_ADDR, PD_ACK_A, PD_WDATA, PD_ACK_D, PD_RDATA, PD_RACK, PD_RLOAD
	} pd_state_t;
	typedef struct packed {
		cmd_t                                   cmd;
		logic                                   cmd_v;
		cfg_t                                   cfg;
		logic                                   dll_rst;
		logic [3:0]                             open;
		logic                                   act;
		logic                                   wr;
		logic                                   ap;
		logic [1:0]                             bank;
		logic [`COL_W-1:0]                      col;
		logic [1:0]                             pair;
		logic [1:0]                             wait_c;
		logic [`DQ_W-1:0]                       dq_r;
		logic [`DQ_W-1:0]                       dq_f;
		logic                                   dq_oe;
		logic [(1<<`MEM_AW)-1:0][`DQ_W-1:0]     mem;
	} link_st_t;
	typedef struct packed {
		logic [1:0]                  scl_s;
		logic [1:0]                  sda_s;
		logic                        scl_h;
		logic                        sda_h;
		logic [1:0][2:0]             sa_s;
		pd_state_t                   st;
		logic [7:0]                  sh;
		logic [3:0]                  bitc;
		logic [7:0]                  ptr;
		logic                        rw;
		logic                        first;
		logic                        oe;
		logic [`PD_BYTES-1:0][7:0]   rom;
	} pd_st_t;
endpackage
`default_nettype wire

// >>> logic/ddr_module.sv
// registered ddr module: command register stage, config register, bursts,
// small array and the i2c presence-detect store
// assumes the controller keeps to the command protocol; CK_T_I is the link clock
//
// How it works
// - commands taken on rising true clock edge
// - write pair taken, read pair driven
// - strobe driven only during read data
// - two pin words per clock, one core word
// - command address picks bank and start column
// - burst lengths two, four or eight
// - auto precharge closes row after burst
// - command held one cycle before use
// - store holds 256 bytes, maker half low
// - straps choose one of eight i2c addresses
// - no hardware write protection on store
// - config set only with bank bits zero
// - delay-loop reset bit clears itself
// - config reload leaves array untouched
// - address bits map to config fields
// - length bounds locations per command
// - burst wraps in aligned block
// - column bit ten excluded, carries precharge
// - low bits pick start; one length
// - order bit picks sequential or interleaved
// - read data follows programmed latency
// - mode bit eight, with other mode bits zero, starts delay-loop reset
`timescale 1ns/1ps
`default_nettype none
module ddr_module #(
	parameter logic [`PD_MAKER*8-1:0] MAKER_DATA = '0
) (
	input  wire logic             MCLK_I,
	input  wire logic             RESET_N_I,
	input  wire logic             CK_T_I,
	input  wire logic             CK_C_I,
	input  wire ddr_pkg::cmd_t    CMD_I,
	input  wire logic [`DQ_W-1:0] DQ_RISE_I,
	input  wire logic [`DQ_W-1:0] DQ_FALL_I,
	input  wire logic             DQS_I,
	output logic [`DQ_W-1:0]      DQ_RISE_O,
	output logic [`DQ_W-1:0]      DQ_FALL_O,
	output logic                  DQ_OE_O,
	output logic                  DQS_O,
	output logic                  DQS_OE_O,
	output logic                  DLL_RESET_O,
	output ddr_pkg::cfg_t         CFG_O,
	output logic [3:0]            BANK_OPEN_O,
	input  wire logic             SCL_I,
	input  wire logic             SDA_I,
	output logic                  SDA_O,
	output logic                  SDA_OE_O,
	input  wire logic [2:0]       SA_I
);
	import ddr_pkg::*;

	// -------------------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------------------
	function automatic logic [2:0] len_mask(input logic [2:0] bl);
		unique case (bl)
			`BL_4:   return 3'h3;
			`BL_8:   return 3'h7;
			default: return 3'h1;
		endcase
	endfunction

	function automatic logic [1:0] lat_cyc(input logic [2:0] cl);
		return (cl == `CL_25) ? `CL_25_CYC : `CL_2_CYC;
	endfunction

	function automatic logic dll_req(input logic [13:0] a);
		return a[13:7] == 7'h02;
	endfunction

	function automatic logic [7:0] ptr_next(input logic [7:0] p);
		return p + 8'h1;
	endfunction

	function automatic logic pd_hit(input logic [7:0] sh, input logic [2:0] sa);
		return sh[7:1] == {`PD_DEV_TYPE, sa};
	endfunction

	// -------------------------------------------------------------------------
	// burst addressing
	// -------------------------------------------------------------------------

	function automatic logic [`MEM_AW-1:0] beat_addr(input logic [1:0]        bank,
	                                                  input logic [`COL_W-1:0] col,
	                                                  input logic [2:0]        beat,
	                                                  input cfg_t              cfg);
		logic [2:0]        m;
		logic [2:0]        off;
		logic [2:0]        o;
		logic [`COL_W-1:0] c;
		m   = len_mask(cfg.bl);
		off = col[2:0] & m;
		o   = cfg.bt ? (off ^ beat) : 3'((off + beat) & m);
		c   = {col[`COL_W-1:3], (col[2:0] & ~m) | (o & m)};
		return {bank, c[`MEM_AW-3:0]};
	endfunction

	// -------------------------------------------------------------------------
	// link domain
	// -------------------------------------------------------------------------
	link_st_t l_q;
	link_st_t l_d;
	logic [2:0]        op;
	logic [`MEM_AW-1:0] a0;
	logic [`MEM_AW-1:0] a1;

	// -------------------------------------------------------------------------
	// link next state
	// -------------------------------------------------------------------------

	always_comb begin
		l_d       = l_q;
		op        = {l_q.cmd.ras_n, l_q.cmd.cas_n, l_q.cmd.we_n};
		a0        = beat_addr(l_q.bank, l_q.col, {l_q.pair, 1'b0}, l_q.cfg);
		a1        = beat_addr(l_q.bank, l_q.col, {l_q.pair, 1'b1}, l_q.cfg);
		l_d.cmd   = CMD_I;
		l_d.cmd_v = ~CK_C_I;
		l_d.dll_rst = 1'b0;
		l_d.cfg.mode[`MODE_DLL_BIT] = 1'b0;
		l_d.dq_oe = 1'b0;
		// ---------------------------------------------------------------------
		// burst stepping
		// ---------------------------------------------------------------------
		if (l_q.act) begin
			if (l_q.wait_c != 2'h0) begin
				l_d.wait_c = l_q.wait_c - 2'h1;
			end else begin
				if (l_q.wr) begin
					if (DQS_I) begin
						l_d.mem[a0] = DQ_RISE_I;
						l_d.mem[a1] = DQ_FALL_I;
					end
				end else begin
					l_d.dq_r  = l_q.mem[a0];
					l_d.dq_f  = l_q.mem[a1];
					l_d.dq_oe = 1'b1;
				end
				l_d.pair = l_q.pair + 2'h1;
				if ({1'b0, l_q.pair} == (len_mask(l_q.cfg.bl) >> 1)) begin
					l_d.act = 1'b0;
					if (l_q.ap) begin
						l_d.open[l_q.bank] = 1'b0;
					end
				end
			end
		end
		// ---------------------------------------------------------------------
		// command stage, one cycle after capture
		// ---------------------------------------------------------------------
		if (l_q.cmd_v && !l_q.cmd.cs_n) begin
			unique case (op)
				`CMD_CFG_SET: begin
					if (l_q.cmd.ba == 2'h0) begin
						l_d.cfg     = cfg_t'(l_q.cmd.addr);
						l_d.dll_rst = dll_req(l_q.cmd.addr);
					end
				end
				`CMD_ACTIVATE: begin
					l_d.open[l_q.cmd.ba] = 1'b1;
				end
				`CMD_PRECHARGE: begin
					if (l_q.cmd.addr[`AP_BIT]) begin
						l_d.open = 4'h0;
					end else begin
						l_d.open[l_q.cmd.ba] = 1'b0;
					end
				end
				`CMD_READ, `CMD_WRITE: begin
					if (l_q.open[l_q.cmd.ba]) begin
						l_d.act    = 1'b1;
						l_d.wr     = ~l_q.cmd.we_n;
						l_d.bank   = l_q.cmd.ba;
						l_d.col    = {l_q.cmd.addr[13:11], l_q.cmd.addr[9:0]};
						l_d.ap     = l_q.cmd.addr[`AP_BIT];
						l_d.pair   = 2'h0;
						l_d.wait_c = l_q.cmd.we_n ? 2'(lat_cyc(l_q.cfg.cl) - 2'h1) : 2'h0;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// -------------------------------------------------------------------------
	// link state register
	// -------------------------------------------------------------------------
	always_ff @(posedge CK_T_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			l_q <= '0;
		end else begin
			l_q <= l_d;
		end
	end

	// -------------------------------------------------------------------------
	// link outputs
	// -------------------------------------------------------------------------
	assign DQ_RISE_O   = l_q.dq_r;
	assign DQ_FALL_O   = l_q.dq_f;
	assign DQ_OE_O     = l_q.dq_oe;
	assign DQS_O       = l_q.dq_oe & CK_T_I;
	assign DQS_OE_O    = l_q.dq_oe;
	assign DLL_RESET_O = l_q.dll_rst;
	assign CFG_O       = l_q.cfg;
	assign BANK_OPEN_O = l_q.open;

	// -------------------------------------------------------------------------
	// presence-detect store, i2c slave on MCLK_I
	// -------------------------------------------------------------------------
	pd_st_t p_q;
	pd_st_t p_d;
	logic   scl;
	logic   sda;
	logic   scl_rise;
	logic   scl_fall;
	logic   start;
	logic   stop;

	always_comb begin
		p_d      = p_q;
		scl      = p_q.scl_s[1];
		sda      = p_q.sda_s[1];
		scl_rise = scl & ~p_q.scl_h;
		scl_fall = ~scl & p_q.scl_h;
		start    = scl & p_q.scl_h & p_q.sda_h & ~sda;
		stop     = scl & p_q.scl_h & ~p_q.sda_h & sda;
		p_d.scl_s = {p_q.scl_s[0], SCL_I};
		p_d.sda_s = {p_q.sda_s[0], SDA_I};
		p_d.sa_s  = {p_q.sa_s[0], SA_I};
		p_d.scl_h = scl;
		p_d.sda_h = sda;
		// ---------------------------------------------------------------------
		// transfer state machine
		// ---------------------------------------------------------------------
		if (start) begin
			p_d.st   = PD_ADDR;
			p_d.bitc = 4'h0;
			p_d.oe   = 1'b0;
		end else if (stop) begin
			p_d.st = PD_IDLE;
			p_d.oe = 1'b0;
		end else if (scl_rise) begin
			unique case (p_q.st)
				PD_ADDR, PD_WDATA: begin
					p_d.sh   = {p_q.sh[6:0], sda};
					p_d.bitc = p_q.bitc + 4'h1;
				end
				PD_RACK: begin
					p_d.st = sda ? PD_IDLE : PD_RLOAD;
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			unique case (p_q.st)
				PD_ADDR: begin
					if (p_q.bitc == 4'h8) begin
						if (pd_hit(p_q.sh, p_q.sa_s[1])) begin
							p_d.st = PD_ACK_A;
							p_d.rw = p_q.sh[0];
							p_d.oe = 1'b1;
						end else begin
							p_d.st = PD_IDLE;
						end
					end
				end
				PD_ACK_A, PD_RLOAD: begin
					if (p_q.rw) begin
						p_d.st   = PD_RDATA;
						p_d.sh   = p_q.rom[p_q.ptr] << 1;
						p_d.oe   = ~p_q.rom[p_q.ptr][7];
						p_d.ptr  = ptr_next(p_q.ptr);
						p_d.bitc = 4'h1;
					end else begin
						p_d.st    = PD_WDATA;
						p_d.first = 1'b1;
						p_d.oe    = 1'b0;
						p_d.bitc  = 4'h0;
					end
				end
				PD_WDATA: begin
					if (p_q.bitc == 4'h8) begin
						if (p_q.first) begin
							p_d.ptr = p_q.sh;
						end else begin
							p_d.rom[p_q.ptr] = p_q.sh;
							p_d.ptr = ptr_next(p_q.ptr);
						end
						p_d.first = 1'b0;
						p_d.st    = PD_ACK_D;
						p_d.oe    = 1'b1;
					end
				end
				PD_ACK_D: begin
					p_d.st   = PD_WDATA;
					p_d.oe   = 1'b0;
					p_d.bitc = 4'h0;
				end
				PD_RDATA: begin
					if (p_q.bitc == 4'h8) begin
						p_d.st = PD_RACK;
						p_d.oe = 1'b0;
					end else begin
						p_d.oe   = ~p_q.sh[7];
						p_d.sh   = p_q.sh << 1;
						p_d.bitc = p_q.bitc + 4'h1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// -------------------------------------------------------------------------
	// store state register
	// -------------------------------------------------------------------------
	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			p_q <= '0;
			p_q.rom[`PD_MAKER-1:0] <= MAKER_DATA;
		end else begin
			p_q <= p_d;
		end
	end

	// -------------------------------------------------------------------------
	// store outputs
	// -------------------------------------------------------------------------
	assign SDA_O    = 1'b0;
	assign SDA_OE_O = p_q.oe;

endmodule // ddr_module
`default_nettype wire

// >>> sim/ddr_module_checker.sv
// link-side assertions for ddr_module
// bound into ddr_module, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module ddr_module_checker (
	input wire logic          RESET_N_I,
	input wire logic          CK_T_I,
	input wire logic          CK_C_I,
	input wire ddr_pkg::cmd_t CMD_I,
	input wire logic          DQ_OE_O,
	input wire logic          DQS_O,
	input wire logic          DQS_OE_O,
	input wire logic          DLL_RESET_O,
	input wire ddr_pkg::cfg_t CFG_O,
	input wire logic [3:0]    BANK_OPEN_O
);
	import ddr_pkg::*;
	logic [2:0] op;
	logic       rd;
	assign op = (CMD_I.cs_n | CK_C_I) ? 3'h7 : {CMD_I.ras_n, CMD_I.cas_n, CMD_I.we_n};
	assign rd = op == `CMD_READ && BANK_OPEN_O[CMD_I.ba];
	default clocking @(posedge CK_T_I); endclocking
	default disable iff (!RESET_N_I);
	cfg_load_a: assert property (op == `CMD_CFG_SET && CMD_I.ba == 2'h0
		|-> ##2 CFG_O == $past(CMD_I.addr, 2)) else $error("config load wrong");
	bit8_clear_a: assert property (CFG_O[8] |=> !CFG_O[8])
		else $error("delay-loop bit stuck");
	dll_pulse_a: assert property (DLL_RESET_O |=> !DLL_RESET_O)
		else $error("delay-loop pulse too long");
	bank_open_a: assert property (op == `CMD_ACTIVATE
		|-> ##2 BANK_OPEN_O[$past(CMD_I.ba, 2)]) else $error("bank not opened");
	read_lat_a: assert property (rd && CFG_O.cl == `CL_2
		|-> ##3 !DQ_OE_O ##1 DQ_OE_O) else $error("read latency two wrong");
	read_half_a: assert property (rd && CFG_O.cl == `CL_25
		|-> ##4 !DQ_OE_O ##1 DQ_OE_O) else $error("read latency 2.5 wrong");
	burst_len_a: assert property (rd && CFG_O.cl == `CL_2 && CFG_O.bl == `BL_8
		|-> ##4 DQ_OE_O [*4] ##1 !DQ_OE_O) else $error("burst length wrong");
	strobe_gate_a: assert property (@(negedge CK_T_I) DQS_O == DQ_OE_O)
		else $error("strobe outside read");
	strobe_oe_a: assert property (DQS_OE_O == DQ_OE_O)
		else $error("strobe enable outside read");
endmodule // ddr_module_checker
bind ddr_module ddr_module_checker i_ddr_module_checker (.RESET_N_I(RESET_N_I),
	.CK_T_I(CK_T_I), .CK_C_I(CK_C_I), .CMD_I(CMD_I), .DQ_OE_O(DQ_OE_O), .DQS_O(DQS_O),
	.DQS_OE_O(DQS_OE_O), .DLL_RESET_O(DLL_RESET_O), .CFG_O(CFG_O), .BANK_OPEN_O(BANK_OPEN_O));
`default_nettype wire

// >>> sim/ddr_ctrl_model.sv
// controller model: commands and write data on the link
// runs on the bench link clock; tasks called by the bench
`timescale 1ns/1ps
`default_nettype none
module ddr_ctrl_model (
	input  wire logic     ck_i,
	output ddr_pkg::cmd_t cmd_o,
	output logic [7:0]    dq_rise_o,
	output logic [7:0]    dq_fall_o,
	output logic          dqs_o
);
	import ddr_pkg::*;
	initial begin
		cmd_o = '1;
		dq_rise_o = 8'h00;
		dq_fall_o = 8'hFF;
		dqs_o = 1'b0;
	end
	// one command for one cycle, then deselect
	task automatic issue(input logic [2:0] op, input logic [1:0] ba, input logic [13:0] a);
		@(posedge ck_i);
		cmd_o <= {1'b0, op, ba, a};
		@(posedge ck_i);
		cmd_o <= {1'b1, ~op, ~ba, ~a};
	endtask
	// write pairs, strobe only while writing
	task automatic burst(input int pairs, input logic [7:0] base);
		for (int k = 0; k < pairs; k++) begin
			@(posedge ck_i);
			dq_rise_o <= base + 8'(2 * k);
			dq_fall_o <= base + 8'(2 * k + 1);
			dqs_o <= 1'b1;
		end
		@(posedge ck_i);
		dq_rise_o <= ~dq_rise_o;
		dq_fall_o <= ~dq_fall_o;
		dqs_o <= 1'b0;
	endtask
endmodule // ddr_ctrl_model
`default_nettype wire

// >>> sim/registered_ddr_module_cmd_burst_test.sv
// bench for the ddr module link side and presence-detect store
// ddr_ctrl_model drives the link; the bench drives the presence-detect pins
`timescale 1ns/1ps
`default_nettype none
module registered_ddr_module_cmd_burst_test;
	import ddr_pkg::*;
	logic       mclk, rst_n, ck_t, ck_c, oe, dll, dqs;
	logic [7:0] dq_r, dq_f, q_r, q_f;
	logic [3:0] bank_open;
	logic       scl, sda_m, sda_oe;
	logic [2:0] sa;
	cmd_t       cmd;
	cfg_t       cfg;
	int         num_errors = 0;
	int         checks_done = 0;
	ddr_module i_ddr_module (.MCLK_I(mclk), .RESET_N_I(rst_n), .CK_T_I(ck_t), .CK_C_I(ck_c),
		.CMD_I(cmd), .DQ_RISE_I(dq_r), .DQ_FALL_I(dq_f), .DQS_I(dqs), .DQ_RISE_O(q_r),
		.DQ_FALL_O(q_f), .DQ_OE_O(oe), .DQS_O(), .DQS_OE_O(), .DLL_RESET_O(dll), .CFG_O(cfg),
		.BANK_OPEN_O(bank_open), .SCL_I(scl), .SDA_I(sda_m & ~sda_oe), .SDA_O(),
		.SDA_OE_O(sda_oe), .SA_I(sa));
	ddr_ctrl_model i_ddr_ctrl_model (.ck_i(ck_t), .cmd_o(cmd), .dq_rise_o(dq_r),
		.dq_fall_o(dq_f), .dqs_o(dqs));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		ck_t = 1'b0;
		ck_c = 1'b1;
		#3;
		forever begin
			#15 ck_c = 1'b0;
			#1 ck_t = 1'b1;
			#15 ck_c = 1'b1;
			#1 ck_t = 1'b0;
		end
	end
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test();
		if (num_errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ck_t);
		#1;
	endtask
	function automatic logic [7:0] loc(input int st, input int len, input logic bt, input int b);
		return 8'h10 + 8'((st & ~(len - 1)) | ((bt ? (st ^ b) : (st + b)) & (len - 1)));
	endfunction
	// ----
	// scenarios
	// ----
	task automatic t_cfg();
		i_ddr_ctrl_model.issue(`CMD_CFG_SET, 2'h0, 14'h0123);
		tick(1);
		check("cfg", 16'h0123, cfg);
		check("dll", 16'h0001, dll);
		tick(1);
		check("cfg clear", 16'h0023, cfg);
		i_ddr_ctrl_model.issue(`CMD_CFG_SET, 2'h1, 14'h3FFF);
		tick(2);
		check("cfg kept", 16'h0023, cfg);
	endtask
	task automatic t_write();
		i_ddr_ctrl_model.issue(`CMD_ACTIVATE, 2'h1, 14'h0000);
		i_ddr_ctrl_model.issue(`CMD_WRITE, 2'h1, 14'h0000);
		i_ddr_ctrl_model.burst(4, 8'h10);
		check("open", 16'h0002, bank_open);
	endtask
	task automatic t_read(input logic [2:0] bl, input logic bt, input logic [2:0] cl,
		input logic [13:0] a);
		int len;
		int n;
		len = 1 << bl;
		i_ddr_ctrl_model.issue(`CMD_CFG_SET, 2'h0, {7'h00, cl, bt, bl});
		i_ddr_ctrl_model.issue(`CMD_READ, 2'h1, a);
		n = 1;
		do begin
			tick(1);
			n++;
		end while (oe !== 1'b1 && n < 12);
		check("latency", (cl == `CL_25) ? 16'd5 : 16'd4, 16'(n));
		for (int k = 0; k < len; k += 2) begin
			check("rise", {8'h00, loc(a[2:0], len, bt, k)}, {8'h00, q_r});
			check("fall", {8'h00, loc(a[2:0], len, bt, k + 1)}, {8'h00, q_f});
			tick(1);
		end
		check("oe end", 16'h0000, oe);
	endtask
	task automatic t_ap();
		int hits;
		hits = 0;
		t_read(`BL_2, 1'b0, `CL_2, 14'h0401);
		tick(4);
		check("closed", 16'h0000, bank_open);
		i_ddr_ctrl_model.issue(`CMD_READ, 2'h1, 14'h0000);
		repeat (8) begin
			tick(1);
			if (oe !== 1'b0)
				hits++;
		end
		check("refused", 16'h0000, 16'(hits));
	endtask
	task automatic i2c_bit(input logic b, output logic got);
		@(posedge mclk);
		sda_m <= b;
		repeat (10) @(posedge mclk);
		scl <= 1'b1;
		repeat (5) @(posedge mclk);
		got = sda_m & ~sda_oe;
		repeat (5) @(posedge mclk);
		scl <= 1'b0;
		repeat (9) @(posedge mclk);
	endtask
	task automatic i2c_edge(input logic stop);
		@(posedge mclk);
		sda_m <= ~stop;
		repeat (10) @(posedge mclk);
		scl <= 1'b1;
		repeat (10) @(posedge mclk);
		sda_m <= ~sda_m;
		repeat (10) @(posedge mclk);
		scl <= stop;
		repeat (10) @(posedge mclk);
	endtask
	task automatic i2c_byte(input logic [7:0] v, output logic [7:0] got, output logic ack_n);
		logic b;
		got = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			i2c_bit(v[i], b);
			got[i] = b;
		end
		i2c_bit(1'b1, ack_n);
	endtask
	task automatic t_store();
		logic [7:0] d;
		logic       ack_n;
		i2c_edge(1'b0);
		i2c_byte({`PD_DEV_TYPE, 3'h2, 1'b0}, d, ack_n);
		check("foreign ack", 16'h0001, 16'(ack_n));
		i2c_edge(1'b1);
		i2c_edge(1'b0);
		i2c_byte({`PD_DEV_TYPE, sa, 1'b0}, d, ack_n);
		check("addr ack", 16'h0000, 16'(ack_n));
		i2c_byte(8'h80, d, ack_n);
		i2c_byte(8'hA5, d, ack_n);
		check("data ack", 16'h0000, 16'(ack_n));
		i2c_edge(1'b1);
		i2c_edge(1'b0);
		i2c_byte({`PD_DEV_TYPE, sa, 1'b0}, d, ack_n);
		i2c_byte(8'h80, d, ack_n);
		i2c_edge(1'b0);
		i2c_byte({`PD_DEV_TYPE, sa, 1'b1}, d, ack_n);
		i2c_byte(8'hFF, d, ack_n);
		check("store byte", 16'h00A5, 16'(d));
		i2c_edge(1'b1);
	endtask
	initial begin
		rst_n = 1'b0;
		scl = 1'b1;
		sda_m = 1'b1;
		sa = 3'h5;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		t_cfg();
		t_write();
		for (int l = 1; l < 4; l++) begin
			for (int t = 0; t < 2; t++) begin
				t_read(3'(l), t[0], `CL_2, 14'h0003);
				t_read(3'(l), t[0], `CL_2, 14'h0006);
			end
		end
		t_read(`BL_4, 1'b0, `CL_25, 14'h0005);
		t_ap();
		t_store();
		finish_test();
	end
	initial begin
		#100000;
		num_errors++;
		finish_test();
	end
endmodule // registered_ddr_module_cmd_burst_test
`default_nettype wire
